// ---- rtl/plmp_cfg.svh ----
`ifndef PLMP_CFG_SVH
`define PLMP_CFG_SVH
// How it works
// - Logic functions always run; unrouted sources read 0
// - Logic outputs recomputed every 4 ms tick
// - AND gate, per-input and output inverters
// - Inverter settings give AND, NAND, OR, NOR
// - Positive delay: output rises after sustained high
// - Negative delay: output falls after sustained low
// - Pot reset holds output at zero
// - Pot runs without a routed destination
// - Pot samples and updates every 4 ms
// - Up request ramps up, down ramps down
// - Up and down together means up
// - Rate is time for 0 to 100 percent
// - Clamp 0..100 or -100..100 by bipolar select
// - Modes 1,3 restore saved value; others start zero
// - Modes 2..4 honour requests only when active
// - Mode 4 zeroes output while drive inactive
// - Scaled output saturates at destination limits

// Tick period
`define PLMP_TICK_MS 4
`define PLMP_CLK_KHZ 100000

// Register word indices (byte address = 4 * index)
`define PLMP_IDX_LF_CTRL 3'h0
`define PLMP_IDX_LF_DELAY 3'h1
`define PLMP_IDX_MP_CTRL 3'h2
`define PLMP_IDX_MP_RATE 3'h3
`define PLMP_IDX_MP_SCALE 3'h4
`define PLMP_IDX_STATUS 3'h5

// Field positions
`define PLMP_LF_STRIDE 8
`define PLMP_LF_INV1 0
`define PLMP_LF_INV2 1
`define PLMP_LF_INVO 2
`define PLMP_MP_MODE_LSB 0
`define PLMP_MP_MODE_MSB 2
`define PLMP_MP_BIPOLAR 4
`define PLMP_MP_RESET 8

// Scale and reset values
`define PLMP_PCT_FULL 17'sh02710
`define PLMP_SCALE_ONE 33'sh0000003e8
`define PLMP_SCALE_RST 16'h03e8
`define PLMP_RATE_RST 16'h1388
`endif

// ---- rtl/plmp_pkg.sv ----
package plmp_pkg;
  typedef enum logic [2:0] {
    MP_ALWAYS_ZERO = 3'b000,
    MP_ALWAYS_KEEP = 3'b001,
    MP_ACTIVE_ZERO = 3'b010,
    MP_ACTIVE_KEEP = 3'b011,
    MP_ACTIVE_FORCE = 3'b100
  } plmp_mode_t;

  typedef enum logic {
    DIV_IDLE = 1'b0,
    DIV_RUN = 1'b1
  } plmp_div_state_t;

  typedef struct packed {
    logic [31:0] tickCnt;
    logic tick;
    logic ack;
    logic [31:0] rdat;
    logic [31:0] lfCtrl;
    logic [31:0] lfDelay;
    logic [31:0] mpCtrl;
    logic [15:0] mpRate;
    logic [15:0] mpScale;
    logic signed [15:0] pos;
    logic [15:0] frac;
    logic [15:0] stepQ;
    logic [15:0] stepR;
    logic divPend;
    logic started;
    logic signed [15:0] dest;
  } plmp_top_st_t;
endpackage : plmp_pkg

// ---- rtl/plmp_lf_if.sv ----
`timescale 1ns/1ps
interface plmp_lf_if #(parameter int DW = 16);
  logic tick;
  logic src1;
  logic src2;
  logic inv1;
  logic inv2;
  logic invOut;
  logic signed [DW-1:0] delay;
  logic out;
  modport ctl (output tick, src1, src2, inv1, inv2, invOut, delay,
    input out);
  modport fn (input tick, src1, src2, inv1, inv2, invOut, delay,
    output out);
endinterface : plmp_lf_if

// ---- rtl/plmp_logic_fn.sv ----
`timescale 1ns/1ps
module plmp_logic_fn import plmp_pkg::*; #(
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  plmp_lf_if.fn lf
);
  typedef struct packed {
    logic [DW-1:0] cnt;
    logic out;
  } plmp_lf_st_t;

  plmp_lf_st_t r_ff;
  plmp_lf_st_t nxt_r;

  always_comb begin
    logic gate;
    logic want;
    logic [DW-1:0] mag;
    gate = 1'b0;
    want = 1'b0;
    mag = '0;
    nxt_r = r_ff;
    gate = ((lf.src1 ^ lf.inv1) & (lf.src2 ^ lf.inv2)) ^ lf.invOut;
    want = ~lf.delay[DW-1];
    mag = lf.delay[DW-1] ? DW'(-lf.delay) : DW'(lf.delay);
    if (lf.tick) begin
      if (lf.delay == '0) begin
        nxt_r.out = gate;
        nxt_r.cnt = '0;
      end else if (gate == want) begin
        if (r_ff.cnt >= mag) begin
          nxt_r.out = want;
        end else begin
          nxt_r.cnt = r_ff.cnt + DW'(1);
        end
      end else begin
        nxt_r.out = ~want;
        nxt_r.cnt = '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r_ff <= '0;
    end else if (ce) begin
      r_ff <= nxt_r;
    end
  end

  assign lf.out = r_ff.out;
endmodule : plmp_logic_fn

// ---- rtl/plmp_div.sv ----
`timescale 1ns/1ps
module plmp_div import plmp_pkg::*; #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic start,
  input wire logic [W-1:0] dividend,
  input wire logic [W-1:0] divisor,
  output logic [W-1:0] quotient,
  output logic [W-1:0] remainder,
  output logic busy,
  output logic done
);
  typedef struct packed {
    plmp_div_state_t st;
    logic [4:0] bitIdx;
    logic [W-1:0] quo;
    logic [W-1:0] rem;
    logic [W-1:0] dvs;
    logic done;
  } plmp_div_st_t;

  plmp_div_st_t r_ff;
  plmp_div_st_t nxt_r;

  always_comb begin
    logic [W:0] remShift;
    logic qBit;
    remShift = '0;
    qBit = 1'b0;
    nxt_r = r_ff;
    nxt_r.done = 1'b0;
    unique case (r_ff.st)
      DIV_IDLE: begin
        if (start) begin
          nxt_r.st = DIV_RUN;
          nxt_r.quo = dividend;
          nxt_r.rem = '0;
          nxt_r.dvs = divisor;
          nxt_r.bitIdx = 5'(W - 1);
        end
      end
      DIV_RUN: begin
        remShift = {r_ff.rem, r_ff.quo[W-1]};
        if (remShift >= {1'b0, r_ff.dvs}) begin
          nxt_r.rem = W'(remShift - {1'b0, r_ff.dvs});
          qBit = 1'b1;
        end else begin
          nxt_r.rem = W'(remShift);
        end
        nxt_r.quo = {r_ff.quo[W-2:0], qBit};
        if (r_ff.bitIdx == 5'h00) begin
          nxt_r.st = DIV_IDLE;
          nxt_r.done = 1'b1;
        end else begin
          nxt_r.bitIdx = r_ff.bitIdx - 5'h01;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r_ff <= '0;
    end else if (ce) begin
      r_ff <= nxt_r;
    end
  end

  assign quotient = r_ff.quo;
  assign remainder = r_ff.rem;
  assign busy = (r_ff.st == DIV_RUN);
  assign done = r_ff.done;
endmodule : plmp_div

// ---- rtl/plmp_top.sv ----
// Chosen here: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "plmp_cfg.svh"
module plmp_top import plmp_pkg::*; #(
  parameter int TICK_CYCLES = `PLMP_TICK_MS * `PLMP_CLK_KHZ,
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [3:0] lfSrc,
  input wire logic [3:0] lfSrcValid,
  input wire logic driveActive,
  input wire logic mpUp,
  input wire logic mpDown,
  input wire logic signed [15:0] mpPowerDownValue,
  output logic [1:0] lfOut,
  output logic signed [15:0] mpOutput,
  output logic signed [15:0] mpDestValue
);
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  plmp_top_st_t r_ff;
  plmp_top_st_t nxt_r;

  logic divStart;
  logic divBusy;
  logic divDone;
  logic [15:0] divQuo;
  logic [15:0] divRem;

  function automatic logic [31:0] wbMerge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] sel);
    logic [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        v[8*b +: 8] = d[8*b +: 8];
      end
    end
    return v;
  endfunction : wbMerge

  function automatic logic signed [15:0] clampPct(
      input logic signed [16:0] v, input logic bip);
    logic signed [16:0] lo;
    lo = bip ? -`PLMP_PCT_FULL : 17'sh00000;
    if (v > `PLMP_PCT_FULL) begin
      return 16'(`PLMP_PCT_FULL);
    end
    if (v < lo) begin
      return 16'(lo);
    end
    return v[15:0];
  endfunction : clampPct

  // Two logic functions, each its own gate and delay stage
  for (genvar i = 0; i < 2; i++) begin : g_lf
    plmp_lf_if #(.DW(DW)) lfIf();
    assign lfIf.tick = r_ff.tick;
    assign lfIf.src1 = lfSrc[2*i] & lfSrcValid[2*i];
    assign lfIf.src2 = lfSrc[2*i+1] & lfSrcValid[2*i+1];
    assign lfIf.inv1 = r_ff.lfCtrl[`PLMP_LF_STRIDE*i + `PLMP_LF_INV1];
    assign lfIf.inv2 = r_ff.lfCtrl[`PLMP_LF_STRIDE*i + `PLMP_LF_INV2];
    assign lfIf.invOut = r_ff.lfCtrl[`PLMP_LF_STRIDE*i + `PLMP_LF_INVO];
    assign lfIf.delay = r_ff.lfDelay[16*i +: DW];
    assign lfOut[i] = lfIf.out;
    plmp_logic_fn #(.DW(DW)) u_fn (
      .clk(clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .lf(lfIf.fn)
    );
  end

  // Step per tick is full scale divided by the rate in ticks
  plmp_div #(.W(16)) u_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .start(divStart),
    .dividend(16'(`PLMP_PCT_FULL)),
    .divisor(r_ff.mpRate),
    .quotient(divQuo),
    .remainder(divRem),
    .busy(divBusy),
    .done(divDone)
  );

  assign divStart = r_ff.divPend & ~divBusy;

  always_comb begin
    plmp_mode_t mode;
    logic bip;
    logic honour;
    logic keepMode;
    logic mapped;
    logic [2:0] idx;
    logic [31:0] rd;
    logic [16:0] fracSum;
    logic signed [16:0] mag;
    logic signed [16:0] delta;
    logic signed [32:0] prod;
    logic signed [32:0] scaled;
    mode = plmp_mode_t'(r_ff.mpCtrl[`PLMP_MP_MODE_MSB:`PLMP_MP_MODE_LSB]);
    bip = r_ff.mpCtrl[`PLMP_MP_BIPOLAR];
    honour = 1'b0;
    keepMode = 1'b0;
    mapped = 1'b0;
    idx = wb_adr_i[4:2];
    rd = '0;
    fracSum = '0;
    mag = '0;
    delta = '0;
    prod = '0;
    scaled = '0;
    nxt_r = r_ff;

    // Tick generator
    if (r_ff.tickCnt >= TICK_LAST) begin
      nxt_r.tickCnt = '0;
      nxt_r.tick = 1'b1;
    end else begin
      nxt_r.tickCnt = r_ff.tickCnt + 32'h00000001;
      nxt_r.tick = 1'b0;
    end

    if (divStart) begin
      nxt_r.divPend = 1'b0;
    end
    if (divDone) begin
      nxt_r.stepQ = divQuo;
      nxt_r.stepR = divRem;
      nxt_r.frac = '0;
    end

    // Wishbone slave, one wait state, unmapped reads zero
    nxt_r.ack = wb_cyc_i & wb_stb_i & ~r_ff.ack;
    mapped = (wb_adr_i[7:5] == 3'h0) && (idx <= `PLMP_IDX_STATUS);
    if (mapped) begin
      unique case (idx)
        `PLMP_IDX_LF_CTRL: rd = r_ff.lfCtrl;
        `PLMP_IDX_LF_DELAY: rd = r_ff.lfDelay;
        `PLMP_IDX_MP_CTRL: rd = r_ff.mpCtrl;
        `PLMP_IDX_MP_RATE: rd = {16'h0000, r_ff.mpRate};
        `PLMP_IDX_MP_SCALE: rd = {16'h0000, r_ff.mpScale};
        default: rd = {13'h0000, r_ff.divPend | divBusy, lfOut,
          r_ff.pos};
      endcase
    end
    nxt_r.rdat = nxt_r.ack ? rd : '0;
    if (nxt_r.ack && wb_we_i && mapped) begin
      unique case (idx)
        `PLMP_IDX_LF_CTRL:
          nxt_r.lfCtrl = wbMerge(r_ff.lfCtrl, wb_dat_i, wb_sel_i);
        `PLMP_IDX_LF_DELAY:
          nxt_r.lfDelay = wbMerge(r_ff.lfDelay, wb_dat_i, wb_sel_i);
        `PLMP_IDX_MP_CTRL:
          nxt_r.mpCtrl = wbMerge(r_ff.mpCtrl, wb_dat_i, wb_sel_i);
        `PLMP_IDX_MP_RATE: begin
          nxt_r.mpRate = 16'(wbMerge({16'h0000, r_ff.mpRate}, wb_dat_i,
            wb_sel_i));
          nxt_r.divPend = 1'b1;
        end
        `PLMP_IDX_MP_SCALE:
          nxt_r.mpScale = 16'(wbMerge({16'h0000, r_ff.mpScale}, wb_dat_i,
            wb_sel_i));
        default: ;
      endcase
    end

    // Motorised pot, updated once per tick
    honour = (mode == MP_ALWAYS_ZERO) || (mode == MP_ALWAYS_KEEP) ||
      driveActive;
    keepMode = (mode == MP_ALWAYS_KEEP) || (mode == MP_ACTIVE_KEEP);
    if (r_ff.tick) begin
      nxt_r.started = 1'b1;
      if (r_ff.mpCtrl[`PLMP_MP_RESET]) begin
        nxt_r.pos = '0;
        nxt_r.frac = '0;
      end else if (!r_ff.started) begin
        nxt_r.pos = keepMode ?
          clampPct(17'(mpPowerDownValue), bip) : 16'sh0000;
        nxt_r.frac = '0;
      end else if (mode == MP_ACTIVE_FORCE && !driveActive) begin
        nxt_r.pos = '0;
        nxt_r.frac = '0;
      end else begin
        if (honour && (mpUp || mpDown)) begin
          fracSum = {1'b0, r_ff.frac} + {1'b0, r_ff.stepR};
          if (r_ff.mpRate == 16'h0000) begin
            mag = `PLMP_PCT_FULL;
          end else if (fracSum >= {1'b0, r_ff.mpRate}) begin
            mag = $signed({1'b0, r_ff.stepQ}) + 17'sh00001;
            nxt_r.frac = 16'(fracSum - {1'b0, r_ff.mpRate});
          end else begin
            mag = $signed({1'b0, r_ff.stepQ});
            nxt_r.frac = fracSum[15:0];
          end
          delta = mpUp ? mag : -mag;
        end
        nxt_r.pos = clampPct(17'(r_ff.pos) + delta, bip);
      end
    end

    // Scaled destination, saturated at full scale
    prod = 33'(r_ff.pos) * $signed({17'h00000, r_ff.mpScale});
    scaled = prod / `PLMP_SCALE_ONE;
    if (scaled > 33'(`PLMP_PCT_FULL)) begin
      nxt_r.dest = 16'(`PLMP_PCT_FULL);
    end else if (scaled < -33'(`PLMP_PCT_FULL)) begin
      nxt_r.dest = 16'(-`PLMP_PCT_FULL);
    end else begin
      nxt_r.dest = scaled[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r_ff <= '0;
      r_ff.mpRate <= `PLMP_RATE_RST;
      r_ff.mpScale <= `PLMP_SCALE_RST;
      r_ff.divPend <= 1'b1;
    end else if (ce) begin
      r_ff <= nxt_r;
    end
  end

  assign wb_dat_o = r_ff.rdat;
  assign wb_ack_o = r_ff.ack;
  assign mpOutput = r_ff.pos;
  assign mpDestValue = r_ff.dest;
endmodule : plmp_top

// ---- testbench/plmp_props.sv ----
`timescale 1ns/1ps
module plmp_props #(
  parameter int TICK_CYCLES = 20
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic mpUp,
  input wire logic mpDown,
  input wire logic [1:0] lfOut,
  input wire logic signed [15:0] mpOutput,
  input wire logic signed [15:0] mpDestValue
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  int lfAge_ff;
  int mpAge_ff;
  // Cycles since each output last moved
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lfAge_ff <= 0;
      mpAge_ff <= 0;
    end else begin
      lfAge_ff <= $changed(lfOut) ? 1 : lfAge_ff + 1;
      mpAge_ff <= $changed(mpOutput) ? 1 : mpAge_ff + 1;
    end
  end
  a_ack_reply: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_lf_tick: assert property (
    $changed(lfOut) && !$past(sys_rst) |-> lfAge_ff >= TICK_CYCLES)
    else $error("logic output moved between ticks");
  a_mp_tick: assert property (
    $changed(mpOutput) && !$past(sys_rst) |-> mpAge_ff >= TICK_CYCLES)
    else $error("pot output moved between ticks");
  a_up_wins: assert property (
    $changed(mpOutput) && mpUp && mpDown && $past(mpUp, 3) &&
    $past(mpDown, 3) |-> mpOutput >= $past(mpOutput))
    else $error("pot fell with both requests");
  a_pot_range: assert property (
    mpOutput >= -16'sh2710 && mpOutput <= 16'sh2710)
    else $error("pot output out of range");
  a_dest_sat: assert property (
    mpDestValue >= -16'sh2710 && mpDestValue <= 16'sh2710)
    else $error("scaled output not saturated");
  c_up_both: cover property (mpUp && mpDown && $changed(mpOutput));
  c_lf_move: cover property ($changed(lfOut));
  c_read: cover property (wb_ack_o && !wb_we_i);
endmodule : plmp_props

bind plmp_top plmp_props #(.TICK_CYCLES(TICK_CYCLES)) uProps (.clk,
  .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .mpUp,
  .mpDown, .lfOut, .mpOutput, .mpDestValue);

// ---- testbench/plmp_drive_model.sv ----
`timescale 1ns/1ps
module plmp_drive_model (
  input wire logic clk,
  output logic [3:0] lfSrc,
  output logic [3:0] lfSrcValid,
  output logic driveActive,
  output logic mpUp,
  output logic mpDown,
  output logic signed [15:0] mpPowerDownValue
);
  initial begin
    lfSrc = 4'h0;
    lfSrcValid = 4'h0;
    driveActive = 1'b0;
    mpUp = 1'b0;
    mpDown = 1'b0;
    // Saved pot value offered at power-up
    mpPowerDownValue = 16'h0bb8;
  end

  task automatic put(input logic [3:0] s, v, input logic a, u, d);
    @(posedge clk);
    lfSrc <= s;
    lfSrcValid <= v;
    driveActive <= a;
    mpUp <= u;
    mpDown <= d;
  endtask : put
endmodule : plmp_drive_model

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  localparam int T = 20;
  localparam logic [7:0] ST = 8'h14;
  localparam logic [15:0] FULL = 16'h2710;
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [3:0] src;
  logic [3:0] vld;
  logic act;
  logic up;
  logic dn;
  logic signed [15:0] pdv;
  logic [1:0] lf;
  logic signed [15:0] pot;
  logic signed [15:0] dest;
  logic [3:0] s;
  logic [3:0] v;
  logic [3:0] m;
  logic signed [15:0] e;
  logic [47:0] expQ[$];
  int nFail = 0;
  int checked = 0;

  initial begin
    forever #5 clk = ~clk;
  end

  plmp_drive_model uDrive (.clk, .lfSrc(src), .lfSrcValid(vld),
    .driveActive(act), .mpUp(up), .mpDown(dn), .mpPowerDownValue(pdv));
  plmp_top #(.TICK_CYCLES(T)) DUT (.clk, .sys_rst(sysRst), .ce(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .lfSrc(src), .lfSrcValid(vld), .driveActive(act), .mpUp(up),
    .mpDown(dn), .mpPowerDownValue(pdv), .lfOut(lf), .mpOutput(pot),
    .mpDestValue(dest));

  task automatic check(input string n, input logic [47:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      nFail++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask : check

  task automatic stopTest;
    $display("checks %0d mismatches %0d", checked, nFail);
    if (nFail == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stopTest

  task automatic giveUp;
    $display("unexpected wait: limit %0d cycles ran out", 3 * T);
    nFail++;
    stopTest();
  endtask : giveUp

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // Ack is sampled at the rising edge; release only after it is seen
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 3 * T);
    if (ack !== 1'b1) giveUp();
    cyc <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [47:0] x);
    expQ.push_back(x);
    wb(1'b0, a, 32'h0);
  endtask : rd

  task automatic tk(input int n);
    repeat (n * T) @(posedge clk);
  endtask : tk

  // Lock onto the tick at which the pot leaves a value, then one tick on
  task automatic align(input logic signed [15:0] from);
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (pot === from && i < 3 * T);
    if (pot === from) giveUp();
    repeat (T) @(negedge clk);
    @(posedge clk);
  endtask : align

  function automatic logic [47:0] st(input logic [1:0] l,
    input logic signed [15:0] p, input logic signed [15:0] d);
    return {d, 14'h0, l, p};
  endfunction : st

  function automatic logic gate(input logic [1:0] x, input logic [2:0] i);
    return ((x[0] ^ i[0]) & (x[1] ^ i[1])) ^ i[2];
  endfunction : gate

  // Read data taken at the same edge at which ack is sampled high
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && expQ.size() > 0) begin
      check("read word", {dest, rdat}, expQ.pop_front());
    end
  end

  initial begin
    void'($urandom(32'h91bc7b2f));
    repeat (3) @(posedge clk);
    sysRst <= 1'b0;
    @(posedge clk);
    tk(1);
    for (int k = 0; k < 16; k++) begin
      s = 4'($urandom);
      v = 4'($urandom);
      m = s & v;
      uDrive.put(s, v, 1'b0, 1'b0, 1'b0);
      wb(1'b1, 8'h00, {21'h0, ~k[2:0], 5'h0, k[2:0]});
      tk(2);
      rd(ST, st({gate(m[3:2], ~k[2:0]), gate(m[1:0], k[2:0])}, 0, 0));
    end
    $display("gate test done");
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b1, 8'h04, 32'h3);
    uDrive.put(4'h3, 4'h3, 1'b0, 1'b0, 1'b0);
    tk(2);
    rd(ST, st(2'h0, 0, 0));
    tk(3);
    rd(ST, st(2'h1, 0, 0));
    uDrive.put(4'h0, 4'h3, 1'b0, 1'b0, 1'b0);
    tk(2);
    rd(ST, st(2'h0, 0, 0));
    wb(1'b1, 8'h04, 32'hfffd);
    uDrive.put(4'h3, 4'h3, 1'b0, 1'b0, 1'b0);
    tk(2);
    rd(ST, st(2'h1, 0, 0));
    uDrive.put(4'h0, 4'h3, 1'b0, 1'b0, 1'b0);
    tk(2);
    rd(ST, st(2'h1, 0, 0));
    tk(3);
    rd(ST, st(2'h0, 0, 0));
    $display("delay test done");
    wb(1'b1, 8'h0c, 32'h4);
    wb(1'b1, 8'h10, 32'h5dc);
    tk(1);
    uDrive.put(4'h0, 4'h0, 1'b0, 1'b1, 1'b0);
    align(16'h0);
    rd(ST, st(2'h0, 16'h1388, 16'h1d4c));
    tk(3);
    rd(ST, st(2'h0, FULL, FULL));
    uDrive.put(4'h0, 4'h0, 1'b0, 1'b0, 1'b1);
    align(FULL);
    rd(ST, st(2'h0, 16'h1388, 16'h1d4c));
    uDrive.put(4'h0, 4'h0, 1'b0, 1'b1, 1'b1);
    tk(3);
    rd(ST, st(2'h0, FULL, FULL));
    uDrive.put(4'h0, 4'h0, 1'b0, 1'b0, 1'b1);
    wb(1'b1, 8'h08, 32'h10);
    tk(10);
    rd(ST, st(2'h0, -FULL, -FULL));
    wb(1'b1, 8'h08, 32'h0);
    tk(2);
    rd(ST, st(2'h0, 0, 0));
    $display("ramp test done");
    for (int k = 0; k < 5; k++) begin
      wb(1'b1, 8'h08, 32'h100 | 32'(k));
      uDrive.put(4'h0, 4'h0, 1'b0, 1'b1, 1'b0);
      tk(2);
      rd(ST, st(2'h0, 0, 0));
      wb(1'b1, 8'h08, 32'(k));
      tk(6);
      e = (k < 2) ? FULL : 16'h0;
      rd(ST, st(2'h0, e, e));
      uDrive.put(4'h0, 4'h0, 1'b1, 1'b1, 1'b0);
      tk(6);
      rd(ST, st(2'h0, FULL, FULL));
      uDrive.put(4'h0, 4'h0, 1'b0, 1'b0, 1'b0);
      tk(2);
      e = (k == 4) ? 16'h0 : FULL;
      rd(ST, st(2'h0, e, e));
    end
    $display("mode test done");
    for (int k = 0; k < 5; k++) begin
      sysRst <= 1'b1;
      @(posedge clk);
      sysRst <= 1'b0;
      @(posedge clk);
      wb(1'b1, 8'h08, 32'(k));
      tk(2);
      e = (k == 1 || k == 3) ? 16'h0bb8 : 16'h0;
      rd(ST, st(2'h0, e, e));
    end
    $display("power-up test done");
    rd(8'h0c, 48'h1388);
    rd(8'h10, 48'h03e8);
    wb(1'b1, ST, 32'h5);
    wb(1'b1, 8'h20, 32'h5);
    rd(ST, st(2'h0, 0, 0));
    rd(8'h20, 48'h0);
    $display("register test done");
    stopTest();
  end
endmodule : testbench
